/* rtl/drb_pkg.sv */
// Constants for the diagnostic record builder
package drb_pkg;
  // Record layout
  localparam int          DRB_REC_BYTES   = 16;
  localparam int          DRB_HDR_BYTES   = 4;
  localparam int          DRB_EXT_BYTES   = 12;
  localparam logic [6:0]  DRB_TYPE_DI     = 7'h70;
  localparam logic [6:0]  DRB_TYPE_FM     = 7'h76;
  localparam logic [7:0]  DRB_BITS_PER_CH = 8'h08;
  localparam logic [7:0]  DRB_NCH_DI      = 8'h08;
  localparam logic [7:0]  DRB_NCH_CNT     = 8'h04;
  localparam logic [3:0]  DRB_CLASS_DIG   = 4'hF;
  localparam logic [3:0]  DRB_CLASS_FUNC  = 4'h8;
  // Register byte addresses
  localparam logic [7:0]  DRB_A_REC0      = 8'h00;
  localparam logic [7:0]  DRB_A_REC3      = 8'h0C;
  localparam logic [7:0]  DRB_A_CTRL      = 8'h10;
  localparam logic [7:0]  DRB_A_STAT      = 8'h14;
  localparam logic [7:0]  DRB_A_MASK      = 8'h18;
  // Control fields
  localparam int          DRB_CTRL_FUNC   = 0;
  localparam int          DRB_CTRL_MORE   = 1;
  localparam int          DRB_CTRL_REL    = 2;
  localparam int          DRB_CTRL_CLR    = 3;
  localparam logic [3:0]  DRB_CTRL_RST    = 4'h4;
  // Status fields
  localparam int          DRB_ST_IN       = 0;
  localparam int          DRB_ST_OUT      = 1;
  localparam int          DRB_ST_LOST     = 2;
  localparam logic [2:0]  DRB_ST_RST      = 3'h0;
  localparam logic [31:0] DRB_BAD_DATA    = 32'hDEADBEEF;
  // Bus answer states
  typedef enum logic [1:0] {
    DRB_IDLE = 2'b00,
    DRB_BUSY = 2'b01,
    DRB_DONE = 2'b11
  } drb_state_t;
endpackage

/* rtl/drb_record.sv */
// Diagnostic record set 1 builder with Avalon-MM register slave
// Notes on behaviour
// - Record is four header bytes then twelve specific bytes, sixteen total.
// - Alarm inputs: byte 4 low seven bits hold type 70h.
// - Byte 4 bit 7 tells whether more channel types exist.
// - Byte 5 holds eight diagnostic bits per channel in both variants.
// - Alarm inputs: byte 6 holds channel count 08h.
// - Alarm inputs: byte 7 low nibble flags errors per two-input group.
// - Alarm inputs: bytes 8-9 carry lost flags on even bits, odd zero; bytes 10-11 zero.
// - Counters: byte 4 low seven bits hold type 76h.
// - Counters: byte 6 holds channel count 04h.
// - Counters: byte 7 low nibble flags an error per counter.
// - Counters 0-2: bits 2,3 lost flags; other bits zero.
// - Counter 3: bits 0 to 4 lost flags, bits 7-5 zero.
// - Byte 1 low nibble gives module class, digital or function.
// - Outgoing message on error removal only while release active.
//
// The Avalon-MM slave port and the placing of the registers were decided locally.
`timescale 1ns/100ps
module drb_record
  import drb_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Avalon-MM slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Diagnostic sources
  input  wire logic [7:0]  rec0_flags,
  input  wire logic        int_supply_lost,
  input  wire logic [3:0]  group_err,
  input  wire logic [7:0]  di_lost,
  input  wire logic [10:0] cnt_lost,
  // Diagnostic messages and interrupt
  output logic             diag_in,
  output logic             diag_out,
  output logic             irq
);

  drb_state_t  state;
  drb_state_t  next_state;
  logic [3:0]  ctrl;
  logic [2:0]  stat;
  logic [2:0]  mask;
  logic [7:0]  rec [DRB_REC_BYTES];
  logic        err_q;
  logic [18:0] lost_q;

  // All checks below share this clock and reset
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  wire logic func_mode = ctrl[DRB_CTRL_FUNC];
  wire logic any_err   = |{rec0_flags[0], group_err};
  wire logic [18:0] lost_now = {cnt_lost, di_lost};
  wire logic err_rise  = any_err & ~err_q;
  wire logic err_fall  = ~any_err & err_q;
  wire logic lost_ev   = |(lost_now & ~lost_q);

  // Eight inputs on the even bits of bytes 8 and 9, odd bits fixed low
  logic [31:0] di_spread;
  always_comb begin
    di_spread = 32'h0;
    for (int k = 0; k < 8; k++) begin
      di_spread[2*k] = di_lost[k];
    end
  end

  // Record assembly
  logic [7:0] next_rec [DRB_REC_BYTES];
  always_comb begin
    next_rec[0] = rec0_flags;
    next_rec[1] = {3'h0, any_err,
                   func_mode ? DRB_CLASS_FUNC : DRB_CLASS_DIG};
    next_rec[2] = {3'h0, int_supply_lost, 4'h0};
    next_rec[3] = 8'h00;
    next_rec[4] = {ctrl[DRB_CTRL_MORE],
                   func_mode ? DRB_TYPE_FM : DRB_TYPE_DI};
    next_rec[5] = DRB_BITS_PER_CH;
    next_rec[6] = func_mode ? DRB_NCH_CNT : DRB_NCH_DI;
    next_rec[7] = {4'h0, group_err};
    for (int i = 0; i < 4; i++) begin
      if (func_mode) begin
        next_rec[8+i] = (i < 3) ?
          {4'h0, cnt_lost[2*i+1], cnt_lost[2*i], 2'b00} :
          {3'h0, cnt_lost[10:6]};
      end else begin
        next_rec[8+i] = di_spread[8*i +: 8];
      end
    end
    for (int i = 12; i < DRB_REC_BYTES; i++) begin
      next_rec[i] = 8'h00;
    end
  end

  // Whole record refreshed every clock, one cycle behind the inputs
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < DRB_REC_BYTES; i++) rec[i] <= 8'h00;
    end else begin
      for (int i = 0; i < DRB_REC_BYTES; i++) begin
        rec[i] <= next_rec[i];
      end
    end
  end

  // Event edges
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      err_q  <= 1'b0;
      lost_q <= 19'h0;
    end else begin
      err_q  <= any_err;
      lost_q <= lost_now;
    end
  end

  // Messages: removal only reported while release still active
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      diag_in  <= 1'b0;
      diag_out <= 1'b0;
    end else begin
      diag_in  <= err_rise & ctrl[DRB_CTRL_REL];
      diag_out <= err_fall & ctrl[DRB_CTRL_REL];
    end
  end

  // Bus decode
  wire logic is_rec  = (address <= DRB_A_REC3) && (address[1:0] == 2'b00);
  wire logic is_ctrl = (address == DRB_A_CTRL);
  wire logic is_stat = (address == DRB_A_STAT);
  wire logic is_mask = (address == DRB_A_MASK);
  wire logic take    = (state == DRB_BUSY);
  // Writes land on the edge where the master sees waitrequest low
  wire logic commit  = (state == DRB_DONE);
  wire logic wr_ctrl = commit & write & is_ctrl & byteenable[0];
  wire logic wr_stat = commit & write & is_stat & byteenable[0];
  wire logic wr_mask = commit & write & is_mask & byteenable[0];
  wire logic [1:0] widx = address[3:2];
  wire logic [31:0] rd_word =
    is_rec  ? {rec[{widx, 2'b11}], rec[{widx, 2'b10}],
               rec[{widx, 2'b01}], rec[{widx, 2'b00}]} :
    is_ctrl ? {28'h0, ctrl} :
    is_stat ? {29'h0, stat} :
    is_mask ? {29'h0, mask} : DRB_BAD_DATA;
  wire logic [2:0] ev = {lost_ev, err_fall, err_rise};

  // One wait cycle, answer on the second edge
  always_comb begin
    case (state)
      DRB_IDLE: next_state = (read | write) ? DRB_BUSY : DRB_IDLE;
      DRB_BUSY: next_state = DRB_DONE;
      default:  next_state = DRB_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state       <= DRB_IDLE;
      waitrequest <= 1'b1;
      readdata    <= 32'h0;
    end else begin
      state       <= next_state;
      waitrequest <= (next_state != DRB_DONE);
      if (take && read) readdata <= rd_word;
    end
  end

  // Control, sticky status (set beats clear), mask, interrupt
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= DRB_CTRL_RST;
      stat <= DRB_ST_RST;
      mask <= 3'h0;
      irq  <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl <= writedata[3:0];
      stat <= ev | (stat & ~(wr_stat ? writedata[2:0] : 3'h0));
      if (wr_mask) mask <= writedata[2:0];
      irq  <= |(stat & mask);
    end
  end

  // Record checks except a_tail_zero run one cycle behind the inputs; nrst in the
  // antecedent keeps the edge that ends reset out of them
  a_type_code: assert property (
    nrst |=> rec[4][6:0] == ($past(func_mode) ? DRB_TYPE_FM : DRB_TYPE_DI))
    else $error("type code wrong");

  a_more_types: assert property (
    nrst |=> rec[4][7] == $past(ctrl[DRB_CTRL_MORE]))
    else $error("more types bit wrong");

  a_bits_count: assert property (
    nrst |=> rec[5] == DRB_BITS_PER_CH)
    else $error("bits count wrong");

  a_chan_count: assert property (
    nrst |=> rec[6] == ($past(func_mode) ? DRB_NCH_CNT : DRB_NCH_DI))
    else $error("channel count wrong");

  a_group_err: assert property (
    nrst |=> rec[7] == {4'h0, $past(group_err)})
    else $error("group error byte wrong");

  a_grp_high_zero: assert property (
    nrst |=> rec[7][7:4] == 4'h0)
    else $error("reserved group bits set");

  a_hdr_copy: assert property (
    nrst |=> rec[0] == $past(rec0_flags))
    else $error("header byte 0 wrong");

  a_supply_bit: assert property (
    nrst |=> rec[2] == {3'h0, $past(int_supply_lost), 4'h0} &&
      rec[3] == 8'h00)
    else $error("header bytes 2 or 3 wrong");

  a_class_code: assert property (
    nrst |=> rec[1][3:0] ==
      ($past(func_mode) ? DRB_CLASS_FUNC : DRB_CLASS_DIG))
    else $error("class code wrong");

  a_tail_zero: assert property (
    (rec[12] | rec[13] | rec[14] | rec[15]) == 8'h00)
    else $error("reserved tail set");

  // Alarm-input lost flags
  a_di_low_map: assert property (
    (nrst && !func_mode) |=> rec[8] ==
      {1'b0, $past(di_lost[3]), 1'b0, $past(di_lost[2]),
       1'b0, $past(di_lost[1]), 1'b0, $past(di_lost[0])})
    else $error("low input lost flags misplaced");

  a_di_even_map: assert property (
    (nrst && !func_mode) |=> rec[9][6] == $past(di_lost[7]))
    else $error("input lost flag misplaced");

  a_di_odd_zero: assert property (
    (nrst && !func_mode) |=> ((rec[8] | rec[9]) & 8'hAA) == 8'h00)
    else $error("odd lost bit set");

  a_di_unused: assert property (
    (nrst && !func_mode) |=> (rec[10] | rec[11]) == 8'h00)
    else $error("unused input lost byte set");

  // Counter lost flags
  a_cnt_lost: assert property (
    (nrst && func_mode) |=> rec[8] == {4'h0, $past(cnt_lost[1:0]), 2'b00})
    else $error("counter lost byte wrong");

  a_cnt_mid: assert property (
    (nrst && func_mode) |=> rec[9] == {4'h0, $past(cnt_lost[3:2]), 2'b00})
    else $error("counter 1 byte wrong");

  a_cnt_two: assert property (
    (nrst && func_mode) |=> rec[10] == {4'h0, $past(cnt_lost[5:4]), 2'b00})
    else $error("counter 2 byte wrong");

  a_cnt3_lost: assert property (
    (nrst && func_mode) |=> rec[11] == {3'h0, $past(cnt_lost[10:6])})
    else $error("counter 3 byte wrong");

  // Messages follow the error edge by one clock, gated by release
  sequence s_raised;
    !err_q ##1 err_q;
  endsequence

  sequence s_removed;
    err_q ##1 !err_q;
  endsequence

  a_in_seq: assert property (
    s_raised |-> diag_in == $past(ctrl[DRB_CTRL_REL]))
    else $error("incoming message wrong");

  a_out_seq: assert property (
    s_removed |-> diag_out == $past(ctrl[DRB_CTRL_REL]))
    else $error("outgoing message wrong");

  a_out_msg: assert property (
    (err_fall && ctrl[DRB_CTRL_REL]) |=> diag_out)
    else $error("outgoing message missing");

  a_out_gated: assert property (
    diag_out |-> $past(ctrl[DRB_CTRL_REL]) && $past(err_fall))
    else $error("outgoing message without release");

  a_in_gated: assert property (
    diag_in |-> $past(ctrl[DRB_CTRL_REL]) && $past(err_rise))
    else $error("incoming message without release");

  a_no_both: assert property (
    !(diag_in && diag_out))
    else $error("both messages at once");

  // Bus answer: busy, one low cycle of waitrequest, then high again
  sequence s_answer;
    waitrequest ##1 !waitrequest ##1 waitrequest;
  endsequence

  a_answer_time: assert property (
    (state == DRB_IDLE && (read || write)) |=> s_answer)
    else $error("bus answer timing wrong");

  a_wait_single: assert property (
    !waitrequest |=> waitrequest)
    else $error("waitrequest low too long");

  a_read_data: assert property (
    (state == DRB_BUSY && read) |=> readdata == $past(rd_word))
    else $error("read data not loaded");

  a_read_hold: assert property (
    (nrst && !(state == DRB_BUSY && read)) |=> $stable(readdata))
    else $error("read data changed without read");

  a_ctrl_write: assert property (
    wr_ctrl |=> ctrl == $past(writedata[3:0]))
    else $error("control write lost");

  a_mask_write: assert property (
    wr_mask |=> mask == $past(writedata[2:0]))
    else $error("mask write lost");

  // Sticky status, set beats clear, interrupt one clock behind
  a_lost_sticky: assert property (
    (nrst && lost_ev) |=> stat[DRB_ST_LOST])
    else $error("lost flag status not set");

  a_in_sticky: assert property (
    (nrst && err_rise) |=> stat[DRB_ST_IN])
    else $error("error status not set");

  a_out_sticky: assert property (
    (nrst && err_fall) |=> stat[DRB_ST_OUT])
    else $error("removal status not set");

  a_irq_level: assert property (
    nrst |=> irq == $past(|(stat & mask)))
    else $error("interrupt level wrong");

endmodule

/* tb/drb_testbench.sv */
// Self-checking bench for the diagnostic record builder
`timescale 1ns/100ps
module testbench
  import drb_pkg::*;
;
  logic        core_clk, nrst, read, write, irq, diag_in, diag_out;
  logic        waitrequest, int_supply_lost;
  logic [7:0]  address, rec0_flags, di_lost;
  logic [3:0]  byteenable, group_err;
  logic [10:0] cnt_lost;
  logic [31:0] writedata, readdata, q;
  int          errors, n_checks, n_in, n_out;

  drb_record uut (.core_clk(core_clk), .nrst(nrst), .address(address),
    .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .rec0_flags(rec0_flags),
    .int_supply_lost(int_supply_lost), .group_err(group_err),
    .di_lost(di_lost), .cnt_lost(cnt_lost), .diag_in(diag_in),
    .diag_out(diag_out), .irq(irq));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Message pulses last one cycle, so count them as they pass
  always @(posedge core_clk) begin
    if (diag_in === 1'b1) n_in++;
    if (diag_out === 1'b1) n_out++;
  end

  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request stays up until waitrequest is sampled low
  task automatic bus(input logic [7:0] a, input logic wr,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    address   <= a;
    read      <= !wr;
    write     <= wr;
    writedata <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 40);
    if (n >= 40) begin
      errors++;
      end_of_test();
    end
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge core_clk);
  endtask

  task automatic rec(input logic [31:0] e0, e1, e2, m2);
    bus(DRB_A_REC0, 1'b0, 32'h0);
    chk(q & 32'hFFFF1FFF, e0);
    bus(8'h04, 1'b0, 32'h0);
    chk(q & 32'h0FFFFFFF, e1);
    bus(8'h08, 1'b0, 32'h0);
    chk(q & m2, e2);
    bus(DRB_A_REC3, 1'b0, 32'h0);
    chk(q, 32'h0);
  endtask

  initial begin
    logic [7:0]  p;
    logic [10:0] c;
    nrst = 1'b0; read = 1'b0; write = 1'b0; address = 8'h00;
    byteenable = 4'hF; writedata = 32'h0; rec0_flags = 8'h00;
    int_supply_lost = 1'b0; group_err = 4'h0; di_lost = 8'h00;
    cnt_lost = 11'h000; errors = 0; n_checks = 0; n_in = 0; n_out = 0;
    idle(3);
    nrst <= 1'b1;
    bus(DRB_A_CTRL, 1'b0, 32'h0);
    chk(q & 32'hF, {28'h0, DRB_CTRL_RST});
    bus(DRB_A_STAT, 1'b0, 32'h0);
    chk(q & 32'h7, 32'h0);
    bus(DRB_A_MASK, 1'b0, 32'h0);
    chk(q & 32'h7, 32'h0);
    // Unmapped place: fixed pattern back, write has no effect
    bus(8'h40, 1'b1, 32'h0000000B);
    bus(8'h40, 1'b0, 32'h0);
    chk(q, DRB_BAD_DATA);
    // Alarm-input variant, two lost-flag patterns
    for (int i = 0; i < 2; i++) begin
      p = i ? 8'h5A : 8'hA5;
      di_lost <= p; group_err <= p[3:0]; int_supply_lost <= p[0];
      rec0_flags <= 8'h02;
      idle(3);
      rec({16'h0, 3'b0, p[0], 4'h0, 8'h1F, 8'h02},
          {4'h0, p[3:0], 8'h08, 8'h08, 8'h70},
          {16'h0, 1'b0, p[7], 1'b0, p[6], 1'b0, p[5], 1'b0, p[4],
           1'b0, p[3], 1'b0, p[2], 1'b0, p[1], 1'b0, p[0]},
          32'hFFFFFFFF);
    end
    // Counter variant with further channel types announced
    bus(DRB_A_CTRL, 1'b1, 32'h7);
    for (int i = 0; i < 2; i++) begin
      c = i ? 11'h2AA : 11'h555;
      cnt_lost <= c; group_err <= c[3:0]; int_supply_lost <= 1'b0;
      idle(3);
      rec({16'h0, 8'h18, 8'h02},
          {4'h0, c[3:0], 8'h04, 8'h08, 8'hF6},
          {3'b0, c[10:6], 4'h0, c[5:4], 2'b0, 4'h0, c[3:2], 2'b0,
           4'h0, c[1:0], 2'b0}, 32'hFFFCFCFC);
    end
    // Messages, sticky status and the level interrupt
    bus(DRB_A_CTRL, 1'b1, 32'h4);
    group_err <= 4'h0; rec0_flags <= 8'h00; di_lost <= 8'h00;
    idle(3);
    bus(DRB_A_STAT, 1'b1, 32'h7);
    n_in = 0; n_out = 0;
    group_err <= 4'h1;
    idle(4);
    chk(n_in, 1);
    group_err <= 4'h0;
    idle(4);
    chk(n_out, 1);
    bus(DRB_A_STAT, 1'b0, 32'h0);
    chk(q & 32'h3, 32'h3);
    chk({31'h0, irq}, 32'h0);
    bus(DRB_A_MASK, 1'b1, 32'h1);
    idle(2);
    chk({31'h0, irq}, 32'h1);
    bus(DRB_A_STAT, 1'b1, 32'h1);
    idle(2);
    chk({31'h0, irq}, 32'h0);
    bus(DRB_A_STAT, 1'b0, 32'h0);
    chk(q & 32'h3, 32'h2);
    // Release off: removal must stay silent
    bus(DRB_A_CTRL, 1'b1, 32'h0);
    group_err <= 4'h2;
    idle(4);
    group_err <= 4'h0;
    idle(4);
    chk(n_out, 1);
    chk(n_in, 1);
    // New lost flag sets its sticky bit, write one clears it
    di_lost <= 8'h01;
    idle(3);
    bus(DRB_A_STAT, 1'b0, 32'h0);
    chk(q & 32'h4, 32'h4);
    bus(DRB_A_STAT, 1'b1, 32'h4);
    bus(DRB_A_STAT, 1'b0, 32'h0);
    chk(q & 32'h4, 32'h0);
    end_of_test();
  end
endmodule
